// ==== src/wait_sequencer.sv ====
// trigger-wait stage of the list step sequencer
// assumes one clock, commands from the list parser as one-cycle pulses
`timescale 1ns/10ps

// Summary of operation
// - A falling-edge wait step advances on a high-to-low trigger or at a non-zero timeout.
// - If trigger is low at edge-step entry, it must rise then fall again.
// - Each wait step drives its programmed output value at entry.
// - A non-zero timeout ends an edge step at edge or expiry, first wins.
// - A zero timeout makes an edge step wait only for the edge.
// - A low-level step with timeout set is skipped if trigger is low.
// - A low-level step entered high ends on low or timeout, first wins.
// - A low-level step with zero timeout waits until trigger is low.
// - Low-level steps count trigger levels only after 2 us of stability.
// - Edge steps still see the trailing edge of pulses under 2 us.
// - A wait command without a prior list entry posts error -221.
// - Edge wait with unequal dwell and value lengths posts error -226.
// - Low wait with unequal dwell and value lengths posts error -236.
// - The step timeout is clamped to 33 ms.
// - While the list runs, any command other than CMD_NONE posts a command error.
module wait_sequencer
   import wait_seq_pkg::*;
#(
   parameter int unsigned TMO_MAX = TIMEOUT_MAX_CYC,
   parameter int unsigned STABLE  = STABLE_CYC
) (
   input  wire logic             CLK_I,
   input  wire logic             RST_B_I,
   input  wire logic             TRIG_I,
   input  wire logic             CMD_VALID_I,
   input  wire cmd_req_t         CMD_I,
   input  wire logic             RUN_I,
   input  wire logic [TMO_W-1:0] TIMEOUT_I,
   input  wire logic             STEP_VALID_I,
   input  wire step_t            STEP_I,
   output logic [VAL_W-1:0]      OUT_VALUE_O,
   output logic                  WAITING_O,
   output logic                  ADVANCE_O,
   output logic                  TIMED_OUT_O,
   output err_t                  ERR_O
);

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_ARM  = 3'b010,
      ST_WAIT = 3'b100
   } state_t;

   // ==========================================================
   // trigger conditioning
   logic level;
   logic fall;
   logic raw;

   trig_filter #(
      .STABLE (STABLE)
   ) u_filt (
      .clk_i   (CLK_I),
      .rst_b_i (RST_B_I),
      .trig_i  (TRIG_I),
      .level_o (level),
      .fall_o  (fall),
      .raw_o   (raw)
   );

   // ==========================================================
   // step state
   state_t           state_reg;
   state_t           state_next;
   logic             is_low_reg;
   logic [TMO_W-1:0] tmo_reg;
   logic [TMO_W-1:0] cnt_reg;
   logic             list_open_reg;

   function automatic logic [TMO_W-1:0] clamp_tmo(input logic [TMO_W-1:0] t);
      if (t > TMO_W'(TMO_MAX)) return TMO_W'(TMO_MAX);
      return t;
   endfunction : clamp_tmo

   function automatic logic is_list_cmd(input cmd_t op);
      return op != CMD_NONE;
   endfunction : is_list_cmd

   logic expired;
   logic hit;
   assign expired = (tmo_reg != '0)
                    && (cnt_reg >= tmo_reg - TMO_W'(1));
   // low steps use filtered level; edge steps use raw fall
   assign hit = is_low_reg ? ~level : fall;

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         ST_IDLE: begin
            if (STEP_VALID_I && RUN_I) begin
               state_next = ST_ARM;
            end
         end
         ST_ARM: begin
            // edge step: raw low at entry needs a rise first
            if (is_low_reg) begin
               if (~level && tmo_reg != '0) begin
                  state_next = ST_IDLE;
               end else begin
                  state_next = ST_WAIT;
               end
            end else if (raw) begin
               state_next = ST_WAIT;
            end else if (expired) begin
               state_next = ST_IDLE;
            end
         end
         ST_WAIT: begin
            if (hit || expired) begin
               state_next = ST_IDLE;
            end
         end
         default: state_next = ST_IDLE;
      endcase
      if (!RUN_I) begin
         state_next = ST_IDLE;
      end
   end

   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         state_reg <= ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // ==========================================================
   // step capture and output value
   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         is_low_reg  <= 1'b0;
         tmo_reg     <= '0;
         OUT_VALUE_O <= '0;
      end else if (state_reg == ST_IDLE && STEP_VALID_I && RUN_I) begin
         is_low_reg  <= STEP_I.is_low;
         tmo_reg     <= clamp_tmo(TIMEOUT_I);
         OUT_VALUE_O <= STEP_I.value;
      end
   end

   // ==========================================================
   // timeout counter, restarted per step
   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         cnt_reg <= '0;
      end else if (state_reg == ST_IDLE) begin
         cnt_reg <= '0;
      end else if (!expired) begin
         cnt_reg <= cnt_reg + TMO_W'(1);
      end
   end

   // ==========================================================
   // status outputs
   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         WAITING_O   <= 1'b0;
         ADVANCE_O   <= 1'b0;
         TIMED_OUT_O <= 1'b0;
      end else begin
         WAITING_O   <= state_next != ST_IDLE;
         ADVANCE_O   <= state_reg != ST_IDLE && state_next == ST_IDLE
                        && RUN_I;
         // trigger wins over a timeout in the same cycle
         // a skip on a low level at entry is not a timeout
         TIMED_OUT_O <= state_reg != ST_IDLE && state_next == ST_IDLE
                        && RUN_I && expired
                        && !(is_low_reg && !level)
                        && !(state_reg == ST_WAIT && hit);
      end
   end

   // ==========================================================
   // command checking
   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         list_open_reg <= 1'b0;
      end else if (CMD_VALID_I && !RUN_I) begin
         if (CMD_I.op == CMD_CURR_LIST || CMD_I.op == CMD_VOLT_LIST) begin
            list_open_reg <= 1'b1;
         end
      end
   end

   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         ERR_O <= '0;
      end else begin
         ERR_O <= '0;
         if (CMD_VALID_I) begin
            if (RUN_I && is_list_cmd(CMD_I.op)) begin
               ERR_O <= '{valid: 1'b1, code: ERR_CMD};
            end else if (CMD_I.op == CMD_WAIT_EDGE
                         || CMD_I.op == CMD_WAIT_LOW) begin
               if (!list_open_reg) begin
                  ERR_O <= '{valid: 1'b1, code: ERR_SETTINGS};
               end else if (CMD_I.dwell_len != CMD_I.value_len) begin
                  ERR_O <= '{valid: 1'b1,
                             code: (CMD_I.op == CMD_WAIT_EDGE)
                                   ? ERR_NOT_SAME
                                   : ERR_UNBALANCE};
               end
            end
         end
      end
   end

endmodule : wait_sequencer

// ==== src/wait_seq_pkg.sv ====
// shared types and constants for the list trigger-wait sequencer
// assumes a single 125 MHz clock domain
package wait_seq_pkg;

   // ==========================================================
   // timing
   localparam int unsigned CLK_MHZ         = 125;
   localparam int unsigned STABLE_NS       = 2000;
   localparam int unsigned STABLE_CYC      = (STABLE_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned TIMEOUT_MAX_MS  = 33;
   localparam int unsigned TIMEOUT_MAX_CYC = TIMEOUT_MAX_MS * CLK_MHZ * 1000;
   localparam int unsigned TMO_W           = 23;
   localparam int unsigned VAL_W           = 16;
   localparam int unsigned LEN_W           = 12;

   // ==========================================================
   // error codes, magnitude of the negative code
   localparam logic [9:0] ERR_NONE      = 10'h000;
   localparam logic [9:0] ERR_SETTINGS  = 10'h0dd; // 221
   localparam logic [9:0] ERR_NOT_SAME  = 10'h0e2; // 226
   localparam logic [9:0] ERR_UNBALANCE = 10'h0ec; // 236
   localparam logic [9:0] ERR_CMD       = 10'h064; // 100, command error

   // ==========================================================
   // command codes
   typedef enum logic [2:0] {
      CMD_NONE      = 3'h0,
      CMD_CURR_LIST = 3'h1,
      CMD_VOLT_LIST = 3'h2,
      CMD_WAIT_EDGE = 3'h3,
      CMD_WAIT_LOW  = 3'h4,
      CMD_OTHER     = 3'h5
   } cmd_t;

   typedef struct packed {
      cmd_t             op;
      logic [LEN_W-1:0] dwell_len;
      logic [LEN_W-1:0] value_len;
   } cmd_req_t;

   typedef struct packed {
      logic             is_low;    // 1 low-level, 0 falling-edge
      logic [VAL_W-1:0] value;
   } step_t;

   typedef struct packed {
      logic       valid;
      logic [9:0] code;
   } err_t;

endpackage : wait_seq_pkg

// ==== src/trig_filter.sv ====
// trigger input synchroniser, stability filter and raw fall detector
// assumes trigger pin is asynchronous to CLK_I
`timescale 1ns/10ps
module trig_filter
   import wait_seq_pkg::*;
#(
   parameter int unsigned STABLE = STABLE_CYC
) (
   input  wire logic clk_i,
   input  wire logic rst_b_i,
   input  wire logic trig_i,
   output logic      level_o,
   output logic      fall_o,
   output logic      raw_o
);
   // ==========================================================
   // synchroniser
   logic       s1_reg;
   logic       s2_reg;
   logic       s3_reg;
   logic [8:0] cnt_reg;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s1_reg <= 1'b1;
         s2_reg <= 1'b1;
         s3_reg <= 1'b1;
      end else begin
         s1_reg <= trig_i;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // ==========================================================
   // level filter: must hold STABLE cycles
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cnt_reg <= '0;
         level_o <= 1'b1;
      end else if (s2_reg == level_o) begin
         cnt_reg <= '0;
      end else if (cnt_reg >= 9'(STABLE - 1)) begin
         cnt_reg <= '0;
         level_o <= s2_reg;
      end else begin
         cnt_reg <= cnt_reg + 9'h001;
      end
   end

   // unfiltered so short pulses still give an edge
   assign fall_o = s3_reg & ~s2_reg;
   assign raw_o  = s2_reg;

endmodule : trig_filter

// ==== tb/wait_seq_monitor.sv ====
// port checker for the trigger-wait sequencer
// assumes a bind onto wait_sequencer, one clock domain
`timescale 1ns/10ps
module wait_seq_monitor
   import wait_seq_pkg::*;
#(
   parameter int unsigned TMO_MAX = TIMEOUT_MAX_CYC,
   parameter int unsigned STABLE  = STABLE_CYC
) (
   input wire logic             CLK_I,
   input wire logic             RST_B_I,
   input wire logic             CMD_VALID_I,
   input wire cmd_req_t         CMD_I,
   input wire logic             RUN_I,
   input wire logic             STEP_VALID_I,
   input wire step_t            STEP_I,
   input wire logic [VAL_W-1:0] OUT_VALUE_O,
   input wire logic             WAITING_O,
   input wire logic             ADVANCE_O,
   input wire logic             TIMED_OUT_O,
   input wire err_t             ERR_O
);
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!RST_B_I);
   // ==========================================================
   // helper: list entry seen outside a run
   logic seen_reg;
   logic lst;
   logic wt;
   assign lst = CMD_I.op == CMD_CURR_LIST || CMD_I.op == CMD_VOLT_LIST;
   assign wt  = CMD_I.op == CMD_WAIT_EDGE || CMD_I.op == CMD_WAIT_LOW;
   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) seen_reg <= 1'b0;
      else if (CMD_VALID_I && !RUN_I && lst) seen_reg <= 1'b1;
   end
   // ==========================================================
   // properties
   sequence s_take;
      STEP_VALID_I && RUN_I && !WAITING_O;
   endsequence
   sequence s_bad_len;
      CMD_VALID_I && !RUN_I && seen_reg && CMD_I.dwell_len != CMD_I.value_len;
   endsequence
   property p_entry;
      s_take |=> WAITING_O && OUT_VALUE_O == $past(STEP_I.value);
   endproperty
   property p_adv_once;
      ADVANCE_O |=> !ADVANCE_O;
   endproperty
   property p_tmo;
      TIMED_OUT_O |-> ADVANCE_O;
   endproperty
   property p_adv_end;
      ADVANCE_O |-> !WAITING_O && $past(WAITING_O);
   endproperty
   property p_e100;
      CMD_VALID_I && RUN_I && lst |=> ERR_O.valid && ERR_O.code == ERR_CMD;
   endproperty
   property p_e221;
      CMD_VALID_I && !RUN_I && wt && !seen_reg
         |=> ERR_O.valid && ERR_O.code == ERR_SETTINGS;
   endproperty
   property p_e226;
      s_bad_len ##0 CMD_I.op == CMD_WAIT_EDGE
         |=> ERR_O.valid && ERR_O.code == ERR_NOT_SAME;
   endproperty
   property p_e236;
      s_bad_len ##0 CMD_I.op == CMD_WAIT_LOW
         |=> ERR_O.valid && ERR_O.code == ERR_UNBALANCE;
   endproperty
   a_entry: assert property (p_entry) else $error("entry value");
   a_adv_once: assert property (p_adv_once) else $error("adv");
   a_tmo: assert property (p_tmo) else $error("timeout alone");
   a_adv_end: assert property (p_adv_end) else $error("adv idle");
   a_e100: assert property (p_e100) else $error("run cmd");
   a_e221: assert property (p_e221) else $error("no list");
   a_e226: assert property (p_e226) else $error("edge len");
   a_e236: assert property (p_e236) else $error("low len");
endmodule : wait_seq_monitor

bind wait_sequencer wait_seq_monitor #(.TMO_MAX(TMO_MAX), .STABLE(STABLE))
   u_mon (.CLK_I(CLK_I), .RST_B_I(RST_B_I), .CMD_VALID_I(CMD_VALID_I),
   .CMD_I(CMD_I), .RUN_I(RUN_I), .STEP_VALID_I(STEP_VALID_I),
   .STEP_I(STEP_I), .OUT_VALUE_O(OUT_VALUE_O), .WAITING_O(WAITING_O),
   .ADVANCE_O(ADVANCE_O), .TIMED_OUT_O(TIMED_OUT_O), .ERR_O(ERR_O));

// ==== tb/trig_src.sv ====
// trigger source model: steady level plus narrow high pulses
// assumes the bench drives it on rising clock edges
`timescale 1ns/10ps
module trig_src (
   input  wire logic clk_i,
   input  wire logic level_i,
   input  wire logic pulse_i,
   output logic      trig_o
);
   // ==========================================================
   // two-cycle pulse, shorter than the level filter on purpose
   logic [1:0] cnt_reg = 2'h0;
   // plain always: the declaration initialiser gives a known idle level
   always @(posedge clk_i) begin
      if (pulse_i) cnt_reg <= 2'h2;
      else if (cnt_reg != 2'h0) cnt_reg <= cnt_reg - 2'h1;
   end
   // levels held for long spans, never glitched
   assign trig_o = (cnt_reg != 2'h0) ? 1'b1 : level_i;
endmodule : trig_src

// ==== tb/wait_sequencer_bench.sv ====
// self-checking bench for the trigger-wait sequencer
// assumes trig_src as the far side and the bound monitor
`timescale 1ns/10ps
module wait_sequencer_bench;
   import wait_seq_pkg::*;
   typedef struct packed {
      cmd_t op; logic [11:0] dl; logic [11:0] vl; logic run; logic [9:0] code;
   } row_t;
   localparam int T = 200;
   logic clk = 0, rst_b = 0, cv = 0, run = 0, sv = 0, lvl = 1, pls = 0;
   logic trig, wt, adv, tout;
   cmd_req_t cmd = '0;
   step_t st = '0;
   logic [TMO_W-1:0] tmo = '0;
   logic [VAL_W-1:0] outv;
   err_t err;
   int errors = 0, tests_run = 0, cyc = 0, n;
   row_t rows [7] = '{
      '{CMD_WAIT_EDGE, 12'h005, 12'h005, 1'b0, ERR_SETTINGS},
      '{CMD_CURR_LIST, 12'h005, 12'h005, 1'b0, ERR_NONE},
      '{CMD_WAIT_EDGE, 12'h004, 12'h005, 1'b0, ERR_NOT_SAME},
      '{CMD_WAIT_LOW, 12'h004, 12'h005, 1'b0, ERR_UNBALANCE},
      '{CMD_WAIT_LOW, 12'h005, 12'h005, 1'b0, ERR_NONE},
      '{CMD_VOLT_LIST, 12'h001, 12'h001, 1'b1, ERR_CMD},
      '{CMD_OTHER, 12'h001, 12'h002, 1'b1, ERR_CMD}};
   always #4 clk = ~clk;
   trig_src u_src (.clk_i(clk), .level_i(lvl), .pulse_i(pls), .trig_o(trig));
   wait_sequencer #(.TMO_MAX(T), .STABLE(4)) u_dut (.CLK_I(clk),
      .RST_B_I(rst_b), .TRIG_I(trig), .CMD_VALID_I(cv), .CMD_I(cmd),
      .RUN_I(run), .TIMEOUT_I(tmo), .STEP_VALID_I(sv), .STEP_I(st),
      .OUT_VALUE_O(outv), .WAITING_O(wt), .ADVANCE_O(adv),
      .TIMED_OUT_O(tout), .ERR_O(err));
   // ==========================================================
   // shared tasks
   task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
      end
   endtask : chk
   task end_of_test;
      $display("checks %0d errors %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : end_of_test
   task start(input logic lo, input logic [VAL_W-1:0] v,
              input logic [TMO_W-1:0] t);
      @(posedge clk); sv <= 1; st <= {lo, v}; tmo <= t;
      @(posedge clk); sv <= 0; #1;
      chk("out value", outv, v);
   endtask : start
   // counts cycles to the advance pulse, capped at lim
   task wadv(input int lim);
      n = 0;
      while (adv !== 1'b1 && n < lim) begin
         @(posedge clk); #1; n++;
      end
   endtask : wadv
   task hold(input logic l);
      @(posedge clk); lvl <= l;
      repeat (20) @(posedge clk);
   endtask : hold
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         errors++;
         end_of_test();
      end
   end
   // ==========================================================
   // main sequence
   initial begin
      repeat (4) @(posedge clk);
      rst_b <= 1;
      foreach (rows[i]) begin
         @(posedge clk); cv <= 1; run <= rows[i].run;
         cmd <= '{rows[i].op, rows[i].dl, rows[i].vl};
         @(posedge clk); cv <= 0; #1;
         chk("error", err.valid ? {1'b1, err.code} : 11'h0, rows[i].code != 0
             ? {1'b1, rows[i].code} : 11'h0);
      end
      start(0, 16'h1111, 0); wadv(30); chk("no fall", n, 30);
      chk("waiting", wt, 1);
      @(posedge clk); lvl <= 0; wadv(10); chk("fall", adv, 1);
      start(0, 16'h2222, 0); wadv(30); chk("low entry", n, 30);
      @(posedge clk); pls <= 1;
      @(posedge clk); pls <= 0;
      wadv(12); chk("pulse", {adv, tout}, 2'b10);
      for (int k = 0; k < 2; k++) begin
         start(0, 16'h3333, 23'h000032); wadv(60);
         chk("tmo", {adv, tout, n >= 48 && n <= 52}, 3'b111);
      end
      start(0, 16'h4444, 23'h7fffff); wadv(250);
      chk("clamp", n >= T - 2 && n <= T + 2, 1);
      start(1, 16'h5555, 23'h000032); wadv(5);
      chk("skip", {adv, tout, n <= 2}, 3'b101);
      hold(1); start(1, 16'h6666, 23'h000032); wadv(10);
      chk("high hold", n, 10);
      @(posedge clk); lvl <= 0; wadv(20);
      chk("low", {adv, tout, n >= 4}, 3'b101);
      hold(1); start(1, 16'h7777, 0); wadv(300);
      chk("no limit", n, 300);
      @(posedge clk); lvl <= 0; wadv(20);
      chk("low zero", {adv, tout}, 2'b10);
      start(0, 16'h8888, 0);
      // dropping run aborts the step with no advance
      @(posedge clk); run <= 0; wadv(3);
      chk("abort", {adv, wt}, 2'b00);
      @(posedge clk); rst_b <= 0;
      @(posedge clk); #1;
      chk("reset", {wt, outv, adv, err.valid}, 19'h0);
      @(posedge clk); rst_b <= 1; run <= 1;
      // pin low across reset: the synchroniser's false fall must not count
      start(0, 16'h9999, 0); wadv(10);
      chk("reset edge", adv, 0);
      end_of_test();
   end
endmodule : wait_sequencer_bench
